// ===== csw_dco_ring.sv
// constants package for the clock switch block and the oscillator ring model
`timescale 1ns/1ps
package csw_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAGE = 8'h01;
  localparam logic [7:0] ADDR_DIV   = 8'h02;
  localparam logic [7:0] ADDR_STEP  = 8'h03;
  // control register field positions
  localparam int BIT_INT_ON     = 0;
  localparam int BIT_EXT_ON     = 1;
  localparam int BIT_SEL        = 2;
  localparam int BIT_MON_EN     = 3;
  localparam int BIT_MON_FLAG   = 4;
  localparam int BIT_MON_IE     = 5;
  localparam int BIT_INT_STABLE = 6;
  localparam int BIT_EXT_STABLE = 7;
  // step register field positions
  localparam int BIT_STEP_UP = 0;
  localparam int BIT_STEP_DN = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic       RST_INT_ON = 1'b1;
  localparam logic       RST_EXT_ON = 1'b0;
  localparam logic       SEL_INT    = 1'b0;
  localparam logic       SEL_EXT    = 1'b1;
  localparam logic [7:0] RST_STAGE  = 8'h00;
  localparam logic [3:0] RST_DIV    = 4'h0;
  // ---------------------------------------------------------------
  // monitor reference dividers: always /4, the fast side also /4096
  // ---------------------------------------------------------------
  localparam int REF_SHORT_LOG2 = 2;
  localparam int REF_LONG_LOG2  = 12;
  localparam int REF_CNT_W      = REF_SHORT_LOG2 + REF_LONG_LOG2;
  localparam logic [1:0] MISS_LIMIT = 2'h2;
  // ---------------------------------------------------------------
  // oscillator geometry
  // ---------------------------------------------------------------
  localparam logic [5:0] RING_BASE    = 6'h11;
  localparam logic [5:0] RING_STEP    = 6'h02;
  localparam logic [5:0] RING_WRAPPED = 6'h22;
  localparam logic [2:0] STAGE_TOP    = 3'h7;
  localparam logic [3:0] DIV_MAX      = 4'h9;
  // clock switch states
  typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_HOLD} csw_sw_type;
endpackage : csw_pkg

// ---------------------------------------------------------------
// oscillator ring model: one clk cycle stands for one stage delay
// ---------------------------------------------------------------
module csw_dco_ring (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] stage_code,
  input  wire logic [3:0] divider_code,
  output logic            dco_tick,
  output logic            dco_level
);
  import csw_pkg::*;

  logic [5:0] dly;
  logic [5:0] next_dly;
  logic [4:0] fine_idx;
  logic [4:0] next_fine_idx;
  logic [8:0] ring_cnt;
  logic [8:0] next_ring_cnt;
  logic       next_dco_tick;
  logic       next_dco_level;
  logic [5:0] base_len;
  logic [5:0] long_len;
  logic [3:0] div_eff;
  logic [8:0] ring_last;

  // length of the coming ring cycle and the binary divide ratio
  always_comb begin
    base_len  = RING_BASE + {2'h0, stage_code[7:5], 1'b0};
    long_len  = (stage_code[7:5] == STAGE_TOP) ? RING_WRAPPED
                                               : base_len + RING_STEP;
    div_eff   = (divider_code > DIV_MAX) ? DIV_MAX : divider_code;
    ring_last = 9'((10'h001 << div_eff) - 10'h001);
  end

  // count stage delays, then ring cycles, then emit an output period
  always_comb begin
    next_dly       = dly;
    next_fine_idx  = fine_idx;
    next_ring_cnt  = ring_cnt;
    next_dco_tick  = 1'b0;
    next_dco_level = dco_level;
    if (dly <= 6'h01) begin
      next_fine_idx = fine_idx + 5'h01;
      // k of every 32 ring cycles run at the longer operating point
      next_dly = (next_fine_idx < stage_code[4:0]) ? long_len : base_len;
      if (ring_cnt >= ring_last) begin
        next_ring_cnt  = 9'h000;
        next_dco_tick  = 1'b1;
        next_dco_level = ~dco_level;
      end else begin
        next_ring_cnt = ring_cnt + 9'h001;
      end
    end else begin
      next_dly = dly - 6'h01;
    end
  end

  // ring state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      dly       <= RING_BASE;
      fine_idx  <= 5'h00;
      ring_cnt  <= 9'h000;
      dco_tick  <= 1'b0;
      dco_level <= 1'b0;
    end else begin
      dly       <= next_dly;
      fine_idx  <= next_fine_idx;
      ring_cnt  <= next_ring_cnt;
      dco_tick  <= next_dco_tick;
      dco_level <= next_dco_level;
    end
  end
endmodule : csw_dco_ring

// ===== csw_clock_switch.sv
// clock source switch, clock monitor and oscillator control registers
//
// Overview of operation
// - a select write only takes if the target clock is on and stable
// - the monitor only runs while both generators are switched on
// - monitor enable may be set only while both stable flags are set
// - clearing the monitor flag needs a prior control read with flag set
// - after that read a zero write clears the flag, a one leaves it
// - monitor enable stays set even if a clock later loses stability
// - on inactivity the live clock drives both outputs and the select bit
// - divider code divides by two to the code, saturating at nine
// - divider code moves only by carry or borrow of the stage code
// - ring length is 17 plus twice the upper three stage bits
// - upper bits all ones use 17 stages then divide by two, 34
// - a clock is dead after two reference low phases without its fall
// - source change: old clock one to two cycles, then low, then new (this implementation runs the old clock only to its next fall)
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps

module csw_clock_switch (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       internal_clock,
  input  wire logic       external_clock,
  input  wire logic       int_stable_in,
  input  wire logic       ext_stable_in,
  input  wire logic       ext_slow_cfg,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            int_gen_on,
  output logic            ext_gen_on,
  output logic            osc_out_clock,
  output logic            timebase_clock,
  output logic            monitor_irq,
  output logic            dco_tick,
  output logic            dco_level
);
  import csw_pkg::*;

  // ---------------------------------------------------------------
  // helper functions shared by both switches and both detectors
  // ---------------------------------------------------------------
  // next state of a glitch-free switch; old_dead skips the drain since
  // a dead clock gives no edge to finish on
  function automatic csw_sw_type sw_step(input csw_sw_type st, input logic differ,
                                         input logic old_fall, input logic old_dead,
                                         input logic new_fall);
    csw_sw_type nx;
    nx = st;
    case (st)
      SW_RUN:   if (differ) nx = old_dead ? SW_HOLD : SW_DRAIN;
      SW_DRAIN: if (old_fall || old_dead) nx = SW_HOLD;
      SW_HOLD:  if (new_fall) nx = SW_RUN;
      default:  nx = SW_RUN;
    endcase
    return nx;
  endfunction : sw_step

  // activity detector: {seen, miss[1:0], dead}
  function automatic logic [3:0] det_step(input logic [3:0] cur, input logic ref_lvl,
                                          input logic ref_rise, input logic mon_fall,
                                          input logic active);
    logic       seen;
    logic [1:0] miss;
    logic       dead;
    seen = cur[3];
    miss = cur[2:1];
    dead = cur[0];
    if (!active) begin
      seen = 1'b0;
      miss = 2'h0;
      dead = 1'b0;
    end else begin
      if (!ref_lvl && mon_fall) begin
        seen = 1'b1;
        miss = 2'h0;
        dead = 1'b0; // a fall while the reference is low revives the clock
      end
      if (ref_rise) begin
        if (!seen && miss < MISS_LIMIT) miss = miss + 2'h1;
        if (!seen && miss >= MISS_LIMIT) dead = 1'b1;
        seen = 1'b0;
      end
    end
    return {seen, miss, dead};
  endfunction : det_step

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] ic_sync;
  logic [1:0] ec_sync;
  logic [1:0] is_sync;
  logic [1:0] es_sync;
  logic       ic_prev;
  logic       ec_prev;
  logic       ic_fall;
  logic       ec_fall;

  // two flops per pin; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (srst) begin
      ic_sync <= 2'h0;
      ec_sync <= 2'h0;
      is_sync <= 2'h0;
      es_sync <= 2'h0;
      ic_prev <= 1'b0;
      ec_prev <= 1'b0;
    end else begin
      ic_sync <= {ic_sync[0], internal_clock};
      ec_sync <= {ec_sync[0], external_clock};
      is_sync <= {is_sync[0], int_stable_in};
      es_sync <= {es_sync[0], ext_stable_in};
      ic_prev <= ic_sync[1];
      ec_prev <= ec_sync[1];
    end
  end

  assign ic_fall = ic_prev & ~ic_sync[1];
  assign ec_fall = ec_prev & ~ec_sync[1];

  // ---------------------------------------------------------------
  // clock monitor: reference dividers and activity detectors
  // ---------------------------------------------------------------
  logic [REF_CNT_W-1:0] idiv;
  logic [REF_CNT_W-1:0] next_idiv;
  logic [REF_CNT_W-1:0] ediv;
  logic [REF_CNT_W-1:0] next_ediv;
  logic                 iref;
  logic                 eref;
  logic                 iref_prev;
  logic                 eref_prev;
  logic [3:0]           idet;
  logic [3:0]           next_idet;
  logic [3:0]           edet;
  logic [3:0]           next_edet;
  logic                 internal_dead;
  logic                 external_dead;
  logic                 mon_active;
  logic                 monitor_enable_bit;

  // the fast side gets the long divider so each reference stays under
  // half the rate of the clock it checks
  assign iref = ext_slow_cfg ? idiv[REF_CNT_W-1] : idiv[REF_SHORT_LOG2-1];
  assign eref = ext_slow_cfg ? ediv[REF_SHORT_LOG2-1] : ediv[REF_CNT_W-1];
  assign mon_active = monitor_enable_bit & int_gen_on & ext_gen_on;
  assign internal_dead = idet[0];
  assign external_dead = edet[0];

  // dividers count falling edges; detectors watch the opposite reference
  always_comb begin
    next_idiv = ic_fall ? idiv + 1'b1 : idiv;
    next_ediv = ec_fall ? ediv + 1'b1 : ediv;
    next_idet = det_step(idet, eref, eref & ~eref_prev, ic_fall, mon_active);
    next_edet = det_step(edet, iref, iref & ~iref_prev, ec_fall, mon_active);
  end

  // monitor registers
  always_ff @(posedge clk) begin
    if (srst) begin
      idiv      <= '0;
      ediv      <= '0;
      iref_prev <= 1'b0;
      eref_prev <= 1'b0;
      idet      <= 4'h0;
      edet      <= 4'h0;
    end else begin
      idiv      <= next_idiv;
      ediv      <= next_ediv;
      iref_prev <= iref;
      eref_prev <= eref;
      idet      <= next_idet;
      edet      <= next_edet;
    end
  end

  // ---------------------------------------------------------------
  // control register, monitor flag and oscillator codes
  // ---------------------------------------------------------------
  logic       clock_select;
  logic       monitor_flag;
  logic       monitor_ie;
  logic       flag_armed;
  logic       int_stable_flag;
  logic       ext_stable_flag;
  logic       dead_prev;
  logic [7:0] stage_code;
  logic [3:0] divider_code;
  logic       next_int_gen_on;
  logic       next_ext_gen_on;
  logic       next_clock_select;
  logic       next_monitor_enable_bit;
  logic       next_monitor_flag;
  logic       next_monitor_ie;
  logic       next_flag_armed;
  logic       next_int_stable_flag;
  logic       next_ext_stable_flag;
  logic [7:0] next_stage_code;
  logic [3:0] next_divider_code;
  logic [7:0] next_reg_rdata;
  logic       next_monitor_irq;
  logic [7:0] ctrl_view;
  logic       any_dead;
  logic       wr_ctrl;
  logic       target_ok;
  logic [8:0] stage_sum;

  assign any_dead  = internal_dead | external_dead;
  assign wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL);
  assign ctrl_view = {ext_stable_flag, int_stable_flag, monitor_ie, monitor_flag,
                      monitor_enable_bit, clock_select, ext_gen_on, int_gen_on};

  // software writes, hardware events and read-back
  always_comb begin
    next_int_gen_on         = int_gen_on;
    next_ext_gen_on         = ext_gen_on;
    next_clock_select       = clock_select;
    next_monitor_enable_bit = monitor_enable_bit;
    next_monitor_flag       = monitor_flag;
    next_monitor_ie         = monitor_ie;
    next_flag_armed         = flag_armed;
    next_stage_code         = stage_code;
    next_divider_code       = divider_code;
    next_reg_rdata          = 8'h00;
    stage_sum               = 9'h000;
    target_ok               = 1'b0;
    // stability drops with the generator or on detected inactivity
    next_int_stable_flag = is_sync[1] & int_gen_on & ~internal_dead;
    next_ext_stable_flag = es_sync[1] & ext_gen_on & ~external_dead;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          next_reg_rdata = ctrl_view;
          if (monitor_flag) next_flag_armed = 1'b1;
        end
        ADDR_STAGE: next_reg_rdata = stage_code;
        ADDR_DIV:   next_reg_rdata = {4'h0, divider_code};
        default:    next_reg_rdata = 8'h00;
      endcase
    end
    if (wr_ctrl) begin
      next_int_gen_on = reg_wdata[BIT_INT_ON];
      next_ext_gen_on = reg_wdata[BIT_EXT_ON];
      next_monitor_ie = reg_wdata[BIT_MON_IE];
      target_ok = reg_wdata[BIT_SEL] ? (ext_gen_on & ext_stable_flag)
                                     : (int_gen_on & int_stable_flag);
      if (target_ok) next_clock_select = reg_wdata[BIT_SEL];
      if (!reg_wdata[BIT_MON_EN]) begin
        next_monitor_enable_bit = 1'b0;
      end else if (int_stable_flag && ext_stable_flag) begin
        next_monitor_enable_bit = 1'b1;
      end
      // no clear on stability loss: the bit keeps its value
      if (!reg_wdata[BIT_MON_FLAG] && flag_armed) begin
        next_monitor_flag = 1'b0;
        next_flag_armed   = 1'b0;
      end
    end
    if (reg_wr && reg_addr == ADDR_STAGE) next_stage_code = reg_wdata;
    if (reg_wr && reg_addr == ADDR_STEP) begin
      // only a carry or borrow out of the stage code moves the divider
      if (reg_wdata[BIT_STEP_UP] && !reg_wdata[BIT_STEP_DN]) begin
        stage_sum = {1'b0, stage_code} + 9'h001;
        if (!stage_sum[8]) begin
          next_stage_code = stage_sum[7:0];
        end else if (divider_code < DIV_MAX) begin
          next_stage_code   = stage_sum[7:0];
          next_divider_code = divider_code + 4'h1;
        end
      end else if (reg_wdata[BIT_STEP_DN] && !reg_wdata[BIT_STEP_UP]) begin
        stage_sum = {1'b0, stage_code} - 9'h001;
        if (!stage_sum[8]) begin
          next_stage_code = stage_sum[7:0];
        end else if (divider_code != RST_DIV) begin
          next_stage_code   = stage_sum[7:0];
          next_divider_code = divider_code - 4'h1;
        end
      end
    end
    // forced selection of the live clock overrides any write
    if (internal_dead) next_clock_select = SEL_EXT;
    if (external_dead) next_clock_select = SEL_INT;
    // a new inactivity event wins over a same-cycle clear
    if (any_dead && !dead_prev) next_monitor_flag = 1'b1;
    next_monitor_irq = next_monitor_flag & next_monitor_ie;
  end

  // control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      int_gen_on         <= RST_INT_ON;
      ext_gen_on         <= RST_EXT_ON;
      clock_select       <= SEL_INT;
      monitor_enable_bit <= 1'b0;
      monitor_flag       <= 1'b0;
      monitor_ie         <= 1'b0;
      flag_armed         <= 1'b0;
      int_stable_flag    <= 1'b0;
      ext_stable_flag    <= 1'b0;
      dead_prev          <= 1'b0;
      stage_code         <= RST_STAGE;
      divider_code       <= RST_DIV;
      reg_rdata          <= 8'h00;
      monitor_irq        <= 1'b0;
    end else begin
      int_gen_on         <= next_int_gen_on;
      ext_gen_on         <= next_ext_gen_on;
      clock_select       <= next_clock_select;
      monitor_enable_bit <= next_monitor_enable_bit;
      monitor_flag       <= next_monitor_flag;
      monitor_ie         <= next_monitor_ie;
      flag_armed         <= next_flag_armed;
      int_stable_flag    <= next_int_stable_flag;
      ext_stable_flag    <= next_ext_stable_flag;
      dead_prev          <= any_dead;
      stage_code         <= next_stage_code;
      divider_code       <= next_divider_code;
      reg_rdata          <= next_reg_rdata;
      monitor_irq        <= next_monitor_irq;
    end
  end

  // ---------------------------------------------------------------
  // glitch-free output switches
  // ---------------------------------------------------------------
  csw_sw_type osc_st;
  csw_sw_type next_osc_st;
  csw_sw_type tb_st;
  csw_sw_type next_tb_st;
  logic       osc_src;
  logic       next_osc_src;
  logic       tb_src;
  logic       next_tb_src;
  logic       tb_req;
  logic       next_osc_out_clock;
  logic       next_timebase_clock;

  // timebase follows the external generator enable unless either clock died
  assign tb_req = internal_dead ? SEL_EXT : (external_dead ? SEL_INT : ext_gen_on);

  // finish on the old clock, hold low, then start on the new clock
  always_comb begin
    next_osc_st = sw_step(osc_st, osc_src != clock_select,
                          osc_src ? ec_fall : ic_fall,
                          osc_src ? external_dead : internal_dead,
                          osc_src ? ic_fall : ec_fall);
    next_tb_st  = sw_step(tb_st, tb_src != tb_req,
                          tb_src ? ec_fall : ic_fall,
                          tb_src ? external_dead : internal_dead,
                          tb_src ? ic_fall : ec_fall);
    next_osc_src = (osc_st == SW_HOLD && next_osc_st == SW_RUN) ? ~osc_src : osc_src;
    next_tb_src  = (tb_st == SW_HOLD && next_tb_st == SW_RUN) ? ~tb_src : tb_src;
    case (next_osc_st)
      SW_RUN:   next_osc_out_clock = next_osc_src ? ec_sync[1] : ic_sync[1];
      SW_DRAIN: next_osc_out_clock = osc_src ? ec_sync[1] : ic_sync[1];
      default:  next_osc_out_clock = 1'b0; // held low while crossing over
    endcase
    case (next_tb_st)
      SW_RUN:   next_timebase_clock = next_tb_src ? ec_sync[1] : ic_sync[1];
      SW_DRAIN: next_timebase_clock = tb_src ? ec_sync[1] : ic_sync[1];
      default:  next_timebase_clock = 1'b0;
    endcase
  end

  // switch registers; both start on the internal clock
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_st         <= SW_RUN;
      tb_st          <= SW_RUN;
      osc_src        <= SEL_INT;
      tb_src         <= SEL_INT;
      osc_out_clock  <= 1'b0;
      timebase_clock <= 1'b0;
    end else begin
      osc_st         <= next_osc_st;
      tb_st          <= next_tb_st;
      osc_src        <= next_osc_src;
      tb_src         <= next_tb_src;
      osc_out_clock  <= next_osc_out_clock;
      timebase_clock <= next_timebase_clock;
    end
  end

  // ---------------------------------------------------------------
  // oscillator period model
  // ---------------------------------------------------------------
  csw_dco_ring u_ring (
    .clk          (clk),
    .srst         (srst),
    .stage_code   (stage_code),
    .divider_code (divider_code),
    .dco_tick     (dco_tick),
    .dco_level    (dco_level)
  );
endmodule : csw_clock_switch

// ===== csw_clock_switch_assertions.sv
// port-level assertions for the clock switch block
`timescale 1ns/1ps

module csw_clock_switch_assertions
  import csw_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rd,
  input wire logic       int_gen_on,
  input wire logic       ext_gen_on,
  input wire logic       monitor_irq,
  input wire logic       dco_tick,
  input wire logic       dco_level
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic [14:0] gap;
  logic [14:0] next_gap;
  logic        ctl_wr;
  // cycles since the last tick; slowest setting (div 9, 34 stages) stays below the limit
  always_comb begin
    next_gap = dco_tick ? 15'h0000 : gap + 15'h0001;
  end
  always_ff @(posedge clk) begin
    gap <= srst ? 15'h0000 : next_gap;
  end
  assign ctl_wr = reg_wr && (reg_addr == ADDR_CTRL);

  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // the shortest ring is 17 stages, so a tick is followed by a quiet stretch
  sequence s_quiet;
    !dco_tick [*8];
  endsequence

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_RST_VALUES:
  assert property (disable iff (1'b0) srst |=> int_gen_on && !ext_gen_on && !monitor_irq
    && reg_rdata == 8'h00 && !dco_tick) else $error("reset values wrong");
  AST_RDATA_IDLE:
  assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data without a read");
  AST_GEN_WRITE:
  assert property (ctl_wr |=> int_gen_on == $past(reg_wdata[BIT_INT_ON])
    && ext_gen_on == $past(reg_wdata[BIT_EXT_ON])) else $error("generator enables not written");
  AST_GEN_HOLD:
  assert property (!ctl_wr |=> $stable(int_gen_on) && $stable(ext_gen_on))
    else $error("generator enable moved without a write");
  AST_IRQ_FALL:
  assert property ($fell(monitor_irq) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("interrupt dropped without a control write");
  AST_TICK_PULSE:
  assert property (dco_tick |=> s_quiet) else $error("oscillator ticks too close");
  AST_LEVEL_AT_TICK:
  assert property (dco_level != $past(dco_level) |-> dco_tick || $past(dco_tick))
    else $error("oscillator level moved away from a tick");
  AST_TICK_GAP:
  assert property (gap < 15'h445C) else $error("oscillator tick missing");
endmodule : csw_clock_switch_assertions

bind csw_clock_switch csw_clock_switch_assertions u_chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .reg_rd(reg_rd), .int_gen_on(int_gen_on), .ext_gen_on(ext_gen_on),
  .monitor_irq(monitor_irq), .dco_tick(dco_tick), .dco_level(dco_level));

// ===== tb_csw_clock_switch.sv
// self-checking bench for the clock switch block
`timescale 1ns/1ps

module tb_csw_clock_switch;
  import csw_pkg::*;
  logic       clk = 1'b0, srst = 1'b1, internal_clock = 1'b0, external_clock = 1'b0;
  logic       ext_stable_in = 1'b0, ext_run = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       int_gen_on, ext_gen_on, osc_out_clock, timebase_clock, monitor_irq;
  logic       dco_tick, dco_level;
  logic [5:0] src_hist = 6'h00;
  int         cnt = 0, fail_count = 0, n_compared = 0;

  csw_clock_switch u_dut (.clk(clk), .srst(srst), .internal_clock(internal_clock),
    .external_clock(external_clock), .int_stable_in(1'b1), .ext_stable_in(ext_stable_in),
    .ext_slow_cfg(1'b0), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_gen_on(int_gen_on), .ext_gen_on(ext_gen_on),
    .osc_out_clock(osc_out_clock), .timebase_clock(timebase_clock), .monitor_irq(monitor_irq),
    .dco_tick(dco_tick), .dco_level(dco_level));

  always #5 clk = ~clk;
  // stand-in source clocks; the external one stops dead when ext_run drops
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cnt % 3 == 0) internal_clock <= ~internal_clock;
    if (ext_run && cnt % 5 == 0) external_clock <= ~external_clock;
    src_hist <= {src_hist[3:0], external_clock, internal_clock}; // pins, three cycles deep
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the read strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // total length of 32 oscillator periods, after skipping the settling ones
  task automatic period32(input logic [15:0] exp);
    int         i;
    logic [15:0] sum;
    sum = 16'h0000;
    for (i = -3; i < 32; ) begin
      @(posedge clk);
      #1;
      if (i >= 0) sum = sum + 16'h0001;
      if (dco_tick === 1'b1) i++;
    end
    chk(sum, exp);
  endtask : period32
  // once a switch has settled, each output shows its source three cycles late
  task automatic chk_out(input logic osc_x, input logic tb_x);
    repeat (20) @(posedge clk);
    repeat (12) begin
      @(posedge clk);
      #1 chk({osc_out_clock, timebase_clock}, {src_hist[4 + osc_x], src_hist[4 + tb_x]});
    end
  endtask : chk_out

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    repeat (4) @(posedge clk);
    chk({int_gen_on, ext_gen_on, monitor_irq, dco_level}, 16'h0008);
    rd(ADDR_CTRL, 8'h41);
  endtask : t_reset
  task automatic t_dco;
    logic [7:0]  stg [6] = '{8'h00, 8'h20, 8'h60, 8'hE0, 8'h01, 8'hE1};
    logic [15:0] len [6] = '{16'h0220, 16'h0260, 16'h02E0, 16'h03E0, 16'h0222, 16'h03E3};
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_STAGE, stg[i]);
      period32(len[i]);
    end
    wr(ADDR_STAGE, 8'hFF);
    wr(ADDR_STEP, 8'h01);
    rd(ADDR_DIV, 8'h01);
    rd(ADDR_STAGE, 8'h00);
    period32(16'h0440);
    wr(ADDR_STEP, 8'h02);
    rd(ADDR_DIV, 8'h00);
    wr(ADDR_STEP, 8'h03);
    rd(ADDR_STAGE, 8'hFF);
    wr(ADDR_STAGE, 8'h00);
  endtask : t_dco
  task automatic t_switch;
    wr(ADDR_CTRL, 8'h0B);
    rd(ADDR_CTRL, 8'h43);
    wr(ADDR_CTRL, 8'h07);
    rd(ADDR_CTRL, 8'h43);
    @(posedge clk) ext_stable_in <= 1'b1;
    repeat (6) @(posedge clk);
    wr(ADDR_CTRL, 8'h07);
    rd(ADDR_CTRL, 8'hC7);
    chk_out(1'b1, 1'b1);
    wr(ADDR_CTRL, 8'h0F);
    wr(ADDR_CTRL, 8'h2F);
    rd(ADDR_CTRL, 8'hEF);
  endtask : t_switch
  // kill the selected external clock; the monitor must fall back to internal
  task automatic t_monitor;
    // a dead crystal no longer reports itself stable either
    @(posedge clk) {ext_run, ext_stable_in} <= 2'b00;
    for (int i = 0; i < 2000 && monitor_irq !== 1'b1; i++) @(posedge clk);
    chk(monitor_irq, 16'h0001);
    chk_out(1'b0, 1'b0);
    wr(ADDR_CTRL, 8'h2B);
    @(posedge clk);
    #1 chk(monitor_irq, 16'h0001);
    rd(ADDR_CTRL, 8'h7B);
    wr(ADDR_CTRL, 8'h3B);
    @(posedge clk);
    #1 chk(monitor_irq, 16'h0001);
    rd(ADDR_CTRL, 8'h7B);
    wr(ADDR_CTRL, 8'h23);
    @(posedge clk);
    #1 chk(monitor_irq, 16'h0000);
    rd(ADDR_CTRL, 8'h63);
  endtask : t_monitor

  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_dco;
    t_switch;
    t_monitor;
    summarize;
  end
  // watchdog: the whole run needs well under a third of this span
  initial begin
    #500000;
    fail_count++;
    summarize;
  end
endmodule : tb_csw_clock_switch
